// ==== src/adc_conversion_sequencer.sv ====
// Conversion sequencer: registers, start/reset control, timing and result capture
//
// Summary of operation
// - After a start pulse the done flag reads high, not complete.
// - Clearing pin selection to zero needs re-initialisation by a new start pulse.
// - A conversion starts on a start bit 0-1-0 pulse.
// - Done flag low means both result registers hold the value.
// - Completion raises a converter interrupt when enabled.
// - A conversion lasts sixteen conversion clock periods, autonomously.
// - Zero pin selection frees all pins and powers the converter down.
// - The converter-off bit powers the converter down regardless of pins.
// - Start held high keeps the converter in reset, done flag high.
// - Completion clears the done flag and sets the interrupt request flag.
// - Result bits 11..4 in high register, 3..0 in low upper nibble.
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Converter side
  input wire logic [11:0] sample_data,
  output logic [7:0] pin_analog_mask,
  output logic [2:0] channel_route,
  output logic converter_powered,
  output logic sample_reset,
  // Interrupt
  output logic irq
);
  import adc_seq_pkg::*;

  main_ctrl_t ctrl;
  irq_en_t irq_en;
  seq_state_t state;
  logic converter_off;
  logic [2:0] clock_divider_sel;
  logic conversion_done_n;
  logic irq_flag;
  logic start_prev;
  logic [4:0] period_cnt;
  logic [7:0] result_hi;
  logic [3:0] result_lo;
  logic conv_tick;

  // Bus decode
  wire logic req = avs_read || avs_write;
  wire logic accept = req && !avs_waitrequest;
  wire logic wr_lane = avs_write && accept && avs_byteenable[0];
  wire logic wr_main = wr_lane && (avs_address == MAIN_CTRL_OFS);
  wire logic wr_clk = wr_lane && (avs_address == CLK_SEL_OFS);
  wire logic wr_irq = wr_lane && (avs_address == IRQ_CTRL_OFS);
  wire logic [7:0] rd_main = {ctrl.start, conversion_done_n, ctrl.analog_pin_sel,
                              ctrl.input_channel_sel};
  wire logic [7:0] rd_clk = {1'b0, converter_off, 3'h0, clock_divider_sel};
  wire logic [7:0] rd_irq = {4'h0, irq_flag, irq_en.converter_irq_enable,
                             irq_en.multifunction_irq_enable, irq_en.global_irq_enable};
  wire logic [7:0] rd_byte = (avs_address == MAIN_CTRL_OFS) ? rd_main :
                             (avs_address == CLK_SEL_OFS) ? rd_clk :
                             (avs_address == RESULT_HI_OFS) ? result_hi :
                             (avs_address == RESULT_LO_OFS) ? {result_lo, 4'h0} :
                             (avs_address == IRQ_CTRL_OFS) ? rd_irq : 8'h00;

  // Sequencer decode
  wire logic enabled = (ctrl.analog_pin_sel != 3'h0) && !converter_off;
  wire logic start_rise = ctrl.start && !start_prev;
  wire logic start_fall = !ctrl.start && start_prev;
  wire logic conv_end = (state == ST_CONVERT) && conv_tick && (period_cnt == CONV_PERIODS - 5'h01);
  wire logic div_clear = (state != ST_CONVERT);
  wire logic irq_set = conv_end;
  wire logic irq_clr = wr_irq && !avs_writedata[IRQ_FLAG_BIT];
  wire logic [7:0] next_mask = (ctrl.analog_pin_sel == PIN_SEL_ALL) ? 8'hFF :
                               8'(~(8'hFF << ctrl.analog_pin_sel));

  conv_clock_gen u_div (
    .clk(clk),
    .rst_b(rst_b),
    .clear(div_clear),
    .clock_divider_sel(clock_divider_sel),
    .tick(conv_tick)
  );

  // Bus answer one cycle after a request appears
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // Software-written registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= '{1'b0, PIN_SEL_RESET, CHAN_SEL_RESET};
      converter_off <= CONV_OFF_RESET;
      clock_divider_sel <= DIV_SEL_RESET;
      irq_en <= '{1'b0, 1'b0, 1'b0};
    end else begin
      if (wr_main)
        ctrl <= '{avs_writedata[START_BIT], avs_writedata[PIN_SEL_LSB +: 3],
                  avs_writedata[CHAN_SEL_LSB +: 3]};
      if (wr_clk) begin
        converter_off <= avs_writedata[CONV_OFF_BIT];
        clock_divider_sel <= avs_writedata[DIV_SEL_LSB +: 3];
      end
      if (wr_irq)
        irq_en <= '{avs_writedata[GLOBAL_EN_BIT], avs_writedata[MULTI_EN_BIT],
                    avs_writedata[CONV_EN_BIT]};
    end
  end

  // Start/reset sequencing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      start_prev <= 1'b0;
      conversion_done_n <= 1'b1;
      period_cnt <= 5'h00;
    end else begin
      start_prev <= ctrl.start;
      if (start_rise || ctrl.start) begin
        state <= ST_HELD;
        conversion_done_n <= 1'b1;
      end else if (!enabled) begin
        state <= ST_IDLE;
      end else begin
        case (state)
          ST_IDLE: state <= ST_IDLE;
          ST_HELD: begin
            if (start_fall) begin
              state <= ST_CONVERT;
              period_cnt <= 5'h00;
            end
          end
          ST_CONVERT: begin
            if (conv_tick)
              period_cnt <= period_cnt + 5'h01;
            if (conv_end) begin
              state <= ST_IDLE;
              conversion_done_n <= 1'b0;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Result capture in the same clock as the done flag clears
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_hi <= 8'h00;
      result_lo <= 4'h0;
    end else if (conv_end && !ctrl.start && enabled) begin
      result_hi <= sample_data[11:4];
      result_lo <= sample_data[3:0];
    end
  end

  // Interrupt request flag, set wins over clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq_flag <= (irq_set && !ctrl.start && enabled) || (irq_flag && !irq_clr);
      irq <= irq_flag && irq_en.global_irq_enable && irq_en.multifunction_irq_enable
             && irq_en.converter_irq_enable;
    end
  end

  // Pin and power outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_analog_mask <= 8'h00;
      channel_route <= 3'h0;
      converter_powered <= 1'b0;
      sample_reset <= 1'b1;
    end else begin
      pin_analog_mask <= next_mask;
      channel_route <= ctrl.input_channel_sel;
      converter_powered <= enabled;
      sample_reset <= (state != ST_CONVERT);
    end
  end

  // Checking helpers
  logic [9:0] conv_cycles;
  logic [9:0] expect_cycles;
  assign expect_cycles = {4'h0, (clock_divider_sel == DIV_SEL_2) ? DIV_RATIO_2 :
                         (clock_divider_sel == DIV_SEL_8) ? DIV_RATIO_8 : DIV_RATIO_32} << 4;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      conv_cycles <= 10'h000;
    else
      conv_cycles <= (state == ST_CONVERT) ? conv_cycles + 10'h001 : 10'h000;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_start_sets_done: assert property (ctrl.start |=> conversion_done_n)
    else $error("done flag not high while start held");
  chk_pulse_done_high: assert property (start_fall |-> ##1 conversion_done_n [*2])
    else $error("done flag low right after start pulse");
  chk_power_down: assert property ((converter_off || ctrl.analog_pin_sel == 3'h0)
    |=> !converter_powered && state != ST_CONVERT)
    else $error("converter active while powered down");
  chk_zero_pins: assert property ((ctrl.analog_pin_sel == 3'h0) |=> pin_analog_mask == 8'h00)
    else $error("pins analog with zero selection");
  chk_result_valid: assert property ($fell(conversion_done_n)
    |-> {result_hi, result_lo} == $past(sample_data))
    else $error("result not valid at completion");
  chk_done_sets_irq: assert property ($fell(conversion_done_n) |-> $rose(irq_flag))
    else $error("request flag not set at completion");
  chk_conv_length: assert property (conv_end |-> conv_cycles == expect_cycles - 10'h001)
    else $error("conversion length wrong");
  chk_irq_gate: assert property ($rose(irq) |-> $past(irq_flag && irq_en.converter_irq_enable
    && irq_en.multifunction_irq_enable && irq_en.global_irq_enable))
    else $error("interrupt without flag and enables");
  chk_bus_answer: assert property ((req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");
endmodule
`default_nettype wire

// ==== src/adc_seq_pkg.sv ====
// Shared constants and types for the conversion sequencer
package adc_seq_pkg;
  // Register byte offsets
  localparam logic [4:0] MAIN_CTRL_OFS = 5'h00;
  localparam logic [4:0] CLK_SEL_OFS = 5'h04;
  localparam logic [4:0] RESULT_HI_OFS = 5'h08;
  localparam logic [4:0] RESULT_LO_OFS = 5'h0C;
  localparam logic [4:0] IRQ_CTRL_OFS = 5'h10;
  // Main control field positions
  localparam int START_BIT = 7;
  localparam int DONE_N_BIT = 6;
  localparam int PIN_SEL_LSB = 3;
  localparam int CHAN_SEL_LSB = 0;
  // Clock select field positions
  localparam int CONV_OFF_BIT = 6;
  localparam int DIV_SEL_LSB = 0;
  // Interrupt control field positions
  localparam int GLOBAL_EN_BIT = 0;
  localparam int MULTI_EN_BIT = 1;
  localparam int CONV_EN_BIT = 2;
  localparam int IRQ_FLAG_BIT = 3;
  // Reset values
  localparam logic [2:0] PIN_SEL_RESET = 3'h0;
  localparam logic [2:0] CHAN_SEL_RESET = 3'h0;
  localparam logic [2:0] DIV_SEL_RESET = 3'h0;
  localparam logic CONV_OFF_RESET = 1'b1;
  // Divider select codes and divide ratios in system clocks
  localparam logic [2:0] DIV_SEL_2 = 3'h0;
  localparam logic [2:0] DIV_SEL_8 = 3'h1;
  localparam logic [2:0] DIV_SEL_32 = 3'h2;
  localparam logic [5:0] DIV_RATIO_2 = 6'h02;
  localparam logic [5:0] DIV_RATIO_8 = 6'h08;
  localparam logic [5:0] DIV_RATIO_32 = 6'h20;
  // Conversion length in conversion clock periods
  localparam logic [4:0] CONV_PERIODS = 5'h10;
  // Pin selection code that routes all eight pins
  localparam logic [2:0] PIN_SEL_ALL = 3'h7;

  typedef struct packed {
    logic start;
    logic [2:0] analog_pin_sel;
    logic [2:0] input_channel_sel;
  } main_ctrl_t;

  typedef struct packed {
    logic global_irq_enable;
    logic multifunction_irq_enable;
    logic converter_irq_enable;
  } irq_en_t;

  typedef enum logic [1:0] {ST_IDLE, ST_HELD, ST_CONVERT} seq_state_t;
endpackage

// ==== src/conv_clock_gen.sv ====
// Conversion clock divider producing one tick per conversion clock period
`timescale 1ns/100ps
`default_nettype none
module conv_clock_gen
  import adc_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic clear,
  input wire logic [2:0] clock_divider_sel,
  // Tick out
  output logic tick
);
  logic [5:0] cnt;
  logic [5:0] ratio;
  wire logic last = (cnt == ratio - 6'h01);

  // Undefined codes fall back to the slowest ratio
  assign ratio = (clock_divider_sel == DIV_SEL_2) ? DIV_RATIO_2 :
                 (clock_divider_sel == DIV_SEL_8) ? DIV_RATIO_8 : DIV_RATIO_32;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 6'h00;
      tick <= 1'b0;
    end else begin
      // Preload one count so the registered tick does not stretch the first period
      cnt <= clear ? 6'h01 : last ? 6'h00 : cnt + 6'h01;
      tick <= !clear && last;
    end
  end
endmodule
`default_nettype wire

// ==== tb/adc_conversion_sequencer_tb.sv ====
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_sequencer_tb;
  import adc_seq_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] sample_data = 12'h000;
  logic [7:0] pin_analog_mask;
  logic [2:0] channel_route;
  logic converter_powered;
  logic sample_reset;
  logic irq;
  int error_cnt = 0;
  int comparisons = 0;
  int conv_cnt = 0;
  logic [31:0] rd;
  logic [5:0] ratio;
  logic [7:0] cfg;
  logic [7:0] en;
  logic [11:0] smp;

  always #50 clk = ~clk;
  // Counts system clocks spent with the converter out of reset
  always @(posedge clk) if (sample_reset === 1'b0) conv_cnt <= conv_cnt + 1;

  adc_conversion_sequencer u_adc_conversion_sequencer (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample_data(sample_data), .pin_analog_mask(pin_analog_mask),
    .channel_route(channel_route), .converter_powered(converter_powered),
    .sample_reset(sample_reset), .irq(irq));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One Avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] adr, input logic [7:0] wd,
                     output logic [31:0] q);
    @(posedge clk);
    avs_address <= adr;
    avs_writedata <= {24'h0, wd};
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] adr, input logic [7:0] wd);
    logic [31:0] q;
    bus(1'b1, adr, wd, q);
  endtask

  task automatic rdchk(input string name, input logic [4:0] adr, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, adr, 8'h00, q);
    chk(name, exp, q);
  endtask

  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  task automatic convert();
    int n;
    @(posedge clk);
    sample_data <= smp;
    wr(MAIN_CTRL_OFS, cfg | 8'h80);
    rdchk("start held", MAIN_CTRL_OFS, {24'h0, cfg | 8'hC0});
    conv_cnt = 0;
    wr(MAIN_CTRL_OFS, cfg);
    rdchk("after pulse", MAIN_CTRL_OFS, {24'h0, cfg | 8'h40});
    n = 0;
    do begin
      bus(1'b0, MAIN_CTRL_OFS, 8'h00, rd);
      n++;
    end while (rd[DONE_N_BIT] !== 1'b0 && n < 400);
    chk("done flag", {24'h0, cfg}, rd);
    chk("conv cycles", {22'h0, ratio, 4'h0}, conv_cnt);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rdchk("main reset", MAIN_CTRL_OFS, 32'h40);
    rdchk("clock reset", CLK_SEL_OFS, 32'h40);
    rdchk("irq reset", IRQ_CTRL_OFS, 32'h00);
    wr(5'h14, 8'hFF);
    rdchk("unmapped", 5'h14, 32'h0);
    wr(RESULT_HI_OFS, 8'hFF);
    rdchk("result ro", RESULT_HI_OFS, 32'h0);
    avs_byteenable <= 4'hE;
    wr(CLK_SEL_OFS, 8'h00);
    avs_byteenable <= 4'hF;
    rdchk("lane off", CLK_SEL_OFS, 32'h40);
    wr(MAIN_CTRL_OFS, 8'h38);
    settle();
    chk("mask all", 32'hFF, {24'h0, pin_analog_mask});
    chk("off powered", 32'h0, {31'h0, converter_powered});
    en = 8'h03;
    wr(IRQ_CTRL_OFS, en);
    for (int i = 0; i < 4; i++) begin
      ratio = (i == 0) ? DIV_RATIO_2 : (i == 1) ? DIV_RATIO_8 : DIV_RATIO_32;
      cfg = 8'h38 | 8'(i * 3);
      smp = 12'hA5C ^ 12'(i * 12'h3F1);
      wr(CLK_SEL_OFS, 8'(i));
      wr(MAIN_CTRL_OFS, cfg);
      settle();
      chk("powered", 32'h1, {31'h0, converter_powered});
      chk("route", {29'h0, cfg[2:0]}, {29'h0, channel_route});
      convert();
      rdchk("result hi", RESULT_HI_OFS, {24'h0, smp[11:4]});
      rdchk("result lo", RESULT_LO_OFS, {24'h0, smp[3:0], 4'h0});
      rdchk("irq flag", IRQ_CTRL_OFS, {24'h0, en | 8'h08});
      settle();
      chk("irq line", {31'h0, en == 8'h07}, {31'h0, irq});
      en = 8'h07;
      wr(IRQ_CTRL_OFS, en);
      rdchk("irq clear", IRQ_CTRL_OFS, {24'h0, en});
      settle();
      chk("irq low", 32'h0, {31'h0, irq});
    end
    wr(MAIN_CTRL_OFS, 8'h18);
    settle();
    chk("mask three", 32'h07, {24'h0, pin_analog_mask});
    wr(MAIN_CTRL_OFS, 8'h98);
    wr(MAIN_CTRL_OFS, 8'h18);
    wr(MAIN_CTRL_OFS, 8'h00);
    settle();
    chk("pins zero mask", 32'h0, {24'h0, pin_analog_mask});
    chk("pins zero power", 32'h0, {31'h0, converter_powered});
    rdchk("abort done", MAIN_CTRL_OFS, 32'h40);
    repeat (600) @(posedge clk);
    rdchk("no completion", IRQ_CTRL_OFS, {24'h0, en});
    rdchk("result kept", RESULT_HI_OFS, {24'h0, smp[11:4]});
    wr(MAIN_CTRL_OFS, 8'h38);
    wr(CLK_SEL_OFS, 8'h40);
    settle();
    chk("off with pins", 32'h0, {31'h0, converter_powered});
    stop_test();
  end

  // Cuts a hang short after well over the expected run length
  initial begin
    #3000000;
    error_cnt++;
    $display("FAIL watchdog expected finish seen hang");
    stop_test();
  end
endmodule
`default_nettype wire
